// ---- dsc_host_model.sv ----
// ************************************************************
// host side of the register path
// ************************************************************
module dsc_host_model
(
	// clock
	input  wire logic              clock,
	// register access toward the device
	output dsc_pkg::dsc_req_s      req,
	input  wire dsc_pkg::dsc_rsp_s rsp
);
	timeunit 1ns;
	timeprecision 1ns;

	// bus addresses the serial side would frame
	localparam logic [7:0] DEV_WR_ADDR = 8'h60;
	localparam logic [7:0] DEV_RD_ADDR = 8'h61;

	// idle bus at time zero
	initial req = '0;

	// one write, raised and dropped on falling edges
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge clock);
		req.wr    = 1'b1;
		req.addr  = a;
		req.wdata = d;
		@(negedge clock);
		req.wr    = 1'b0;
		req.wdata = ~d; // stale data must not be reused
	endtask

	// one read; unknown back when no answer came
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge clock);
		req.rd   = 1'b1;
		req.addr = a;
		@(negedge clock);
		req.rd   = 1'b0;
		d = rsp.rvalid ? rsp.rdata : 8'hxx;
	endtask

	// page choice made before touching paged addresses
	task automatic page(input logic [7:0] p);
		wr(8'hff, p);
	endtask
endmodule

// ---- dsc_pkg.sv ----
package dsc_pkg;

	// ************************************************************
	// register offsets
	// ************************************************************
	localparam logic [7:0] OFS_BLOCK_RESET  = 8'he0;
	localparam logic [7:0] OFS_MASTER_SPEED = 8'hf0;
	localparam logic [7:0] OFS_SLAVE_ID     = 8'hf7;
	localparam logic [7:0] OFS_SLAVE_CTRL   = 8'hf8;
	localparam logic [7:0] OFS_SELFTEST     = 8'hf9;
	localparam logic [7:0] OFS_PTR_LOW      = 8'hfa;
	localparam logic [7:0] OFS_PTR_HIGH     = 8'hfb;
	localparam logic [7:0] OFS_DATA_PORT    = 8'hfc;
	localparam logic [7:0] OFS_PROTO_CMD    = 8'hfd;
	localparam logic [7:0] OFS_PROTO_STAT   = 8'hfe;
	localparam logic [7:0] OFS_PAGE_SEL     = 8'hff;

	// ************************************************************
	// reset values
	// ************************************************************
	localparam logic [7:0] RST_BLOCK_RESET  = 8'h04;
	localparam logic [7:0] RST_MASTER_SPEED = 8'h04;
	localparam logic [7:0] RST_SLAVE_ID     = 8'h5a; // arbitrary value
	localparam logic [7:0] RST_SLAVE_CTRL   = 8'h01;
	localparam logic [7:0] RST_SELFTEST     = 8'h00;
	localparam logic [7:0] RST_PTR          = 8'h00;
	localparam logic [7:0] RST_DATA_PORT    = 8'h80;
	localparam logic [7:0] RST_PROTO        = 8'h00;
	localparam logic [7:0] RST_PAGE_SEL     = 8'h7f;
	localparam logic [7:0] RSVD_READ        = 8'h00;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int CTRL_PASSTHRU   = 0;
	localparam int CTRL_MASTER_EN  = 1;
	localparam int CTRL_MCLK_DELAY = 2;
	localparam int CTRL_SLAVE_EN   = 3;
	localparam int CTRL_AUTO_INC   = 5;
	localparam int BIST_LAUNCH     = 0;
	localparam int BIST_MRESET_OS  = 1;
	localparam int BIST_ERR_LSB    = 2;
	localparam int BIST_BOOT_SEL   = 6;
	localparam int BIST_MRESET     = 7;
	localparam int PAGE_BIT        = 0;

	// ************************************************************
	// sizes and timing counts
	// ************************************************************
	localparam int PMEM_AW     = 14;
	localparam int PMEM_DEPTH  = 12288;
	localparam logic [8:0] MCLK_EXTRA = 9'h004; // added tick delay

	// ************************************************************
	// carriers
	// ************************************************************
	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dsc_req_s;

	typedef struct packed {
		logic       rvalid;
		logic [7:0] rdata;
	} dsc_rsp_s;

endpackage

// ---- dsc_prog_mem.sv ----
module dsc_prog_mem
(
	// clock and reset
	input  wire logic                          clock,
	input  wire logic                          rst_n,
	// access
	input  wire logic                          we,
	input  wire logic [dsc_pkg::PMEM_AW-1:0]   addr,
	input  wire logic [7:0]                    wdata,
	output logic      [7:0]                    rdata_q
);

	logic [7:0] mem [dsc_pkg::PMEM_DEPTH];

	// array write, no reset so it maps to block ram
	always_ff @(posedge clock)
	begin
		if (we)
			mem[addr] <= wdata;
	end

	// registered read of the current pointer
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rdata_q <= 8'h00;
		else
			rdata_q <= mem[addr];
	end

endmodule

// ---- dsc_regs.sv ----
module dsc_regs
(
	// clock and reset
	input  wire logic              clock,
	input  wire logic              rst_n,
	// register access from the serial slave
	input  wire dsc_pkg::dsc_req_s req,
	output dsc_pkg::dsc_rsp_s      rsp_q,
	// self-test status from the microcontroller
	input  wire logic [3:0]        bist_err,
	input  wire logic              bist_busy,
	// microcontroller controls
	output logic                   bist_launch_q,
	output logic                   micro_reset_pulse_q,
	output logic                   micro_reset_q,
	output logic                   boot_rom_sel_q,
	// block controls
	output logic [7:0]             block_reset_q,
	output logic [7:0]             slave_id_q,
	output logic                   passthru_en_q,
	output logic                   master_en_q,
	output logic                   slave_en_q,
	output logic                   auto_inc_q,
	output logic                   master_tick_q,
	output logic                   page_sensor_q,
	output logic [7:0]             proto_cmd_q
);

	// ************************************************************
	// register state
	// ************************************************************
	logic [7:0]  speed_q;
	logic [7:0]  ctrl_q;
	logic [7:0]  ptr_lo_q;
	logic [7:0]  ptr_hi_q;
	logic [7:0]  data_q;
	logic [7:0]  stat_q;
	logic [7:0]  page_q;
	logic [7:0]  mem_rdata;
	logic        fetch1_q;
	logic        fetch2_q;
	logic [8:0]  tick_cnt_q;
	logic [8:0]  tick_limit;
	logic [15:0] ptr;
	logic        mem_we;
	logic [7:0]  rdata_d;

	// write strobe per register
	function automatic logic hit(input logic [7:0] ofs);
		hit = req.wr && (req.addr == ofs);
	endfunction

	assign ptr    = {ptr_hi_q, ptr_lo_q};
	assign mem_we = hit(dsc_pkg::OFS_DATA_PORT);

	// ************************************************************
	// program memory
	// ************************************************************
	dsc_prog_mem u_mem
	(
		.clock   (clock),
		.rst_n   (rst_n),
		.we      (mem_we),
		.addr    (ptr[dsc_pkg::PMEM_AW-1:0]),
		.wdata   (req.wdata),
		.rdata_q (mem_rdata)
	);

	// ************************************************************
	// plain read-write registers
	// ************************************************************
	// block resets, serial master speed and slave id
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			block_reset_q <= dsc_pkg::RST_BLOCK_RESET;
			speed_q       <= dsc_pkg::RST_MASTER_SPEED;
			slave_id_q    <= dsc_pkg::RST_SLAVE_ID;
		end
		else
		begin
			if (hit(dsc_pkg::OFS_BLOCK_RESET))
				block_reset_q <= req.wdata;
			if (hit(dsc_pkg::OFS_MASTER_SPEED))
				speed_q <= req.wdata;
			if (hit(dsc_pkg::OFS_SLAVE_ID))
				slave_id_q <= req.wdata;
		end
	end

	// slave control, decoded bits mirrored to ports
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			ctrl_q <= dsc_pkg::RST_SLAVE_CTRL;
		else if (hit(dsc_pkg::OFS_SLAVE_CTRL))
			ctrl_q <= req.wdata;
	end

	// outputs straight from the same write so they track ctrl_q
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			passthru_en_q <= 1'b1;
			master_en_q   <= 1'b0;
			slave_en_q    <= 1'b0;
			auto_inc_q    <= 1'b0;
		end
		else if (hit(dsc_pkg::OFS_SLAVE_CTRL))
		begin
			passthru_en_q <= req.wdata[dsc_pkg::CTRL_PASSTHRU];
			master_en_q   <= req.wdata[dsc_pkg::CTRL_MASTER_EN];
			slave_en_q    <= req.wdata[dsc_pkg::CTRL_SLAVE_EN];
			auto_inc_q    <= req.wdata[dsc_pkg::CTRL_AUTO_INC];
		end
	end

	// protocol command, status and page select
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			proto_cmd_q   <= dsc_pkg::RST_PROTO;
			stat_q        <= dsc_pkg::RST_PROTO;
			page_q        <= dsc_pkg::RST_PAGE_SEL;
			page_sensor_q <= dsc_pkg::RST_PAGE_SEL[dsc_pkg::PAGE_BIT];
		end
		else
		begin
			if (hit(dsc_pkg::OFS_PROTO_CMD))
				proto_cmd_q <= req.wdata;
			if (hit(dsc_pkg::OFS_PROTO_STAT))
				stat_q <= req.wdata;
			if (hit(dsc_pkg::OFS_PAGE_SEL))
			begin
				page_q        <= req.wdata;
				page_sensor_q <= req.wdata[dsc_pkg::PAGE_BIT];
			end
		end
	end

	// ************************************************************
	// program memory pointer and data port
	// ************************************************************
	// pointer bytes; fetch pipeline waits out the memory latency
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			ptr_lo_q <= dsc_pkg::RST_PTR;
			ptr_hi_q <= dsc_pkg::RST_PTR;
			fetch1_q <= 1'b0;
			fetch2_q <= 1'b0;
		end
		else
		begin
			if (hit(dsc_pkg::OFS_PTR_LOW))
				ptr_lo_q <= req.wdata;
			if (hit(dsc_pkg::OFS_PTR_HIGH))
				ptr_hi_q <= req.wdata;
			fetch1_q <= hit(dsc_pkg::OFS_PTR_LOW) ||
				hit(dsc_pkg::OFS_PTR_HIGH);
			fetch2_q <= fetch1_q && !mem_we; // port write beats stale fetch
		end
	end

	// data port: a write goes through, a pointer move refetches
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			data_q <= dsc_pkg::RST_DATA_PORT;
		else if (mem_we)
			data_q <= req.wdata;
		else if (fetch2_q)
			data_q <= mem_rdata;
	end

	// ************************************************************
	// self-test and microcontroller reset
	// ************************************************************
	// one-shot pulses last exactly one cycle per write
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			bist_launch_q       <= 1'b0;
			micro_reset_pulse_q <= 1'b0;
			micro_reset_q       <= dsc_pkg::RST_SELFTEST[dsc_pkg::BIST_MRESET];
			boot_rom_sel_q      <= dsc_pkg::RST_SELFTEST[dsc_pkg::BIST_BOOT_SEL];
		end
		else
		begin
			bist_launch_q <= hit(dsc_pkg::OFS_SELFTEST) &&
				req.wdata[dsc_pkg::BIST_LAUNCH];
			micro_reset_pulse_q <= hit(dsc_pkg::OFS_SELFTEST) &&
				req.wdata[dsc_pkg::BIST_MRESET_OS];
			if (hit(dsc_pkg::OFS_SELFTEST))
			begin
				micro_reset_q  <= req.wdata[dsc_pkg::BIST_MRESET];
				boot_rom_sel_q <= req.wdata[dsc_pkg::BIST_BOOT_SEL];
			end
		end
	end

	// ************************************************************
	// internal serial master clock tick
	// ************************************************************
	// the delay bit stretches every period by a fixed count
	assign tick_limit = {1'b0, speed_q} +
		(ctrl_q[dsc_pkg::CTRL_MCLK_DELAY] ? dsc_pkg::MCLK_EXTRA : 9'h000);

	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
		begin
			tick_cnt_q    <= 9'h000;
			master_tick_q <= 1'b0;
		end
		else if (!ctrl_q[dsc_pkg::CTRL_MASTER_EN])
		begin
			tick_cnt_q    <= 9'h000;
			master_tick_q <= 1'b0;
		end
		else if (tick_cnt_q >= tick_limit)
		begin
			tick_cnt_q    <= 9'h000;
			master_tick_q <= 1'b1;
		end
		else
		begin
			tick_cnt_q    <= tick_cnt_q + 9'h001;
			master_tick_q <= 1'b0;
		end
	end

	// ************************************************************
	// read path
	// ************************************************************
	// address decode; unmapped offsets give a fixed zero
	always_comb
	begin
		if (req.addr == dsc_pkg::OFS_BLOCK_RESET)
			rdata_d = block_reset_q;
		else if (req.addr == dsc_pkg::OFS_MASTER_SPEED)
			rdata_d = speed_q;
		else if (req.addr == dsc_pkg::OFS_SLAVE_ID)
			rdata_d = slave_id_q;
		else if (req.addr == dsc_pkg::OFS_SLAVE_CTRL)
			rdata_d = ctrl_q;
		else if (req.addr == dsc_pkg::OFS_SELFTEST)
			rdata_d = {micro_reset_q, boot_rom_sel_q, bist_err,
				bist_busy, 1'b0};
		else if (req.addr == dsc_pkg::OFS_PTR_LOW)
			rdata_d = ptr_lo_q;
		else if (req.addr == dsc_pkg::OFS_PTR_HIGH)
			rdata_d = ptr_hi_q;
		else if (req.addr == dsc_pkg::OFS_DATA_PORT)
			rdata_d = data_q;
		else if (req.addr == dsc_pkg::OFS_PROTO_CMD)
			rdata_d = proto_cmd_q;
		else if (req.addr == dsc_pkg::OFS_PROTO_STAT)
			rdata_d = stat_q;
		else if (req.addr == dsc_pkg::OFS_PAGE_SEL)
			rdata_d = page_q;
		else
			rdata_d = dsc_pkg::RSVD_READ;
	end

	// answer one cycle after the read strobe
	always_ff @(posedge clock or negedge rst_n)
	begin
		if (!rst_n)
			rsp_q <= '0;
		else
		begin
			rsp_q.rvalid <= req.rd;
			rsp_q.rdata  <= req.rd ? rdata_d : 8'h00;
		end
	end

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (!rst_n);

	sequence s_ptr_write;
		hit(dsc_pkg::OFS_PTR_LOW) || hit(dsc_pkg::OFS_PTR_HIGH);
	endsequence

	// no port write and no second pointer move while the fetch lands
	sequence s_quiet_port;
		!mem_we ##1 (!mem_we && !hit(dsc_pkg::OFS_PTR_LOW) &&
			!hit(dsc_pkg::OFS_PTR_HIGH)) ##1 !mem_we;
	endsequence

	AST_PTR_COMBINE: assert property (
		hit(dsc_pkg::OFS_PTR_HIGH) |=> ptr[15:8] == $past(req.wdata))
		else $error("pointer high byte not stored");

	AST_DATA_REFETCH: assert property (
		s_ptr_write ##0 s_quiet_port |=> data_q === mem_rdata)
		else $error("data port not refetched after pointer move");

	AST_BIST_ERR_READ: assert property (req.rd &&
		req.addr == dsc_pkg::OFS_SELFTEST
		|=> rsp_q.rdata[5:2] == $past(bist_err))
		else $error("self-test error flags misread");

	AST_ONESHOT: assert property (micro_reset_pulse_q
		|=> !micro_reset_pulse_q || $past(hit(dsc_pkg::OFS_SELFTEST)))
		else $error("microcontroller reset pulse too long");

	AST_LAUNCH: assert property (hit(dsc_pkg::OFS_SELFTEST) &&
		req.wdata[dsc_pkg::BIST_LAUNCH] |=> bist_launch_q)
		else $error("self-test launch missing");

	AST_PASSTHRU: assert property (passthru_en_q
		== ctrl_q[dsc_pkg::CTRL_PASSTHRU])
		else $error("pass-through enable out of step");

	AST_TICK_GAP: assert property (master_tick_q
		&& ctrl_q[dsc_pkg::CTRL_MCLK_DELAY]
		|=> !master_tick_q [*4])
		else $error("delayed master clock ticked too soon");

	AST_PAGE: assert property (hit(dsc_pkg::OFS_PAGE_SEL)
		|=> page_sensor_q == $past(req.wdata[0]))
		else $error("page select not taken");

	AST_STATUS_RW: assert property (
		hit(dsc_pkg::OFS_PROTO_STAT) ##1 !req.wr
		##1 (req.rd && req.addr == dsc_pkg::OFS_PROTO_STAT && !req.wr)
		|=> rsp_q.rdata == $past(req.wdata, 3))
		else $error("protocol status not read back");

	AST_RSVD: assert property (req.rd
		&& req.addr > dsc_pkg::OFS_BLOCK_RESET
		&& req.addr < dsc_pkg::OFS_MASTER_SPEED
		|=> rsp_q.rvalid && rsp_q.rdata == dsc_pkg::RSVD_READ)
		else $error("reserved address returned data");

endmodule

// ---- tb_dsp_system_control_regs.sv ----
module tb_dsp_system_control_regs;
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// signals
	// ************************************************************
	logic              clock;
	logic              rst_n;
	dsc_pkg::dsc_req_s req;
	dsc_pkg::dsc_rsp_s rsp_q;
	logic [3:0]        bist_err;
	logic              bist_busy;
	logic              bist_launch_q, micro_reset_pulse_q, micro_reset_q;
	logic              boot_rom_sel_q, passthru_en_q, master_en_q;
	logic              slave_en_q, auto_inc_q, master_tick_q;
	logic              page_sensor_q;
	logic [7:0]        block_reset_q, slave_id_q, proto_cmd_q;
	logic [7:0]        v;
	int                n_fail, n_checks;

	dsc_host_model host_u (.clock(clock), .req(req), .rsp(rsp_q));

	dsc_regs dut_u
	(
		.clock(clock), .rst_n(rst_n), .req(req), .rsp_q(rsp_q),
		.bist_err(bist_err), .bist_busy(bist_busy),
		.bist_launch_q(bist_launch_q),
		.micro_reset_pulse_q(micro_reset_pulse_q),
		.micro_reset_q(micro_reset_q), .boot_rom_sel_q(boot_rom_sel_q),
		.block_reset_q(block_reset_q), .slave_id_q(slave_id_q),
		.passthru_en_q(passthru_en_q), .master_en_q(master_en_q),
		.slave_en_q(slave_en_q), .auto_inc_q(auto_inc_q),
		.master_tick_q(master_tick_q), .page_sensor_q(page_sensor_q),
		.proto_cmd_q(proto_cmd_q)
	);

	// ************************************************************
	// helpers
	// ************************************************************
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask

	// read one offset and compare
	task automatic rchk(input logic [7:0] a, input logic [7:0] e);
		host_u.rd(a, v);
		chk($sformatf("reg %h", a), e, v);
	endtask

	// cycles between two ticks, second gap so a rate change has settled
	task automatic tick_gap(output logic [7:0] n);
		int k;
		for (int g = 0; g < 2; g++)
		begin
			k = 0;
			while (master_tick_q !== 1'b1 && k < 60)
			begin
				@(negedge clock);
				k++;
			end
			n = 8'h00;
			do
			begin
				@(negedge clock);
				n++;
			end
			while (master_tick_q !== 1'b1 && n < 8'd60);
		end
	endtask

	// ************************************************************
	// scenarios
	// ************************************************************
	task automatic t_reset_values();
		logic [7:0] ofs [11] = '{8'he0, 8'hf0, 8'hf7, 8'hf8, 8'hf9,
			8'hfa, 8'hfb, 8'hfc, 8'hfd, 8'hfe, 8'hff};
		logic [7:0] exp [11] = '{dsc_pkg::RST_BLOCK_RESET,
			dsc_pkg::RST_MASTER_SPEED, dsc_pkg::RST_SLAVE_ID,
			dsc_pkg::RST_SLAVE_CTRL, 8'h00, 8'h00, 8'h00, 8'h80,
			8'h00, 8'h00, 8'h7f};
		chk("passthru", 8'h01, {7'h0, passthru_en_q});
		chk("page", 8'h01, {7'h0, page_sensor_q});
		for (int i = 0; i < 11; i++)
			rchk(ofs[i], exp[i]);
	endtask

	task automatic t_reserved();
		host_u.wr(8'he1, 8'h3c);
		host_u.wr(8'hf1, 8'hc3);
		rchk(8'he1, dsc_pkg::RSVD_READ);
		rchk(8'he1, dsc_pkg::RSVD_READ);
		rchk(8'hf0, 8'h04);
		rchk(8'he0, 8'h04);
	endtask

	task automatic t_pointer();
		host_u.wr(8'hfb, 8'h01);
		host_u.wr(8'hfa, 8'h05);
		host_u.wr(8'hfc, 8'haa);
		rchk(8'hfc, 8'haa);
		host_u.wr(8'hfa, 8'h06);
		host_u.wr(8'hfc, 8'h55);
		host_u.wr(8'hfa, 8'h05);
		repeat (3) @(negedge clock);
		rchk(8'hfc, 8'haa);
		host_u.wr(8'hfb, 8'h00);
		repeat (3) @(negedge clock);
		rchk(8'hfa, 8'h05);
		rchk(8'hfb, 8'h00);
		host_u.wr(8'hfb, 8'h01);
		host_u.wr(8'hfa, 8'h06);
		repeat (3) @(negedge clock);
		rchk(8'hfc, 8'h55);
	endtask

	task automatic t_selftest();
		bist_err  = 4'ha;
		bist_busy = 1'b1;
		rchk(8'hf9, 8'h2a);
		bist_err  = 4'h5;
		bist_busy = 1'b0;
		rchk(8'hf9, 8'h14);
		host_u.wr(8'hf9, 8'h03);
		chk("launch", 8'h01, {7'h0, bist_launch_q});
		chk("mreset", 8'h01, {7'h0, micro_reset_pulse_q});
		@(negedge clock);
		chk("launch end", 8'h00, {7'h0, bist_launch_q});
		chk("mreset end", 8'h00, {7'h0, micro_reset_pulse_q});
		host_u.wr(8'hf9, 8'h01);
		chk("launch only", 8'h00, {7'h0, micro_reset_pulse_q});
		chk("launch again", 8'h01, {7'h0, bist_launch_q});
		bist_err = 4'h0;
		host_u.wr(8'hf9, 8'hc0);
		chk("micro reset", 8'h01, {7'h0, micro_reset_q});
		chk("boot sel", 8'h01, {7'h0, boot_rom_sel_q});
		rchk(8'hf9, 8'hc0);
	endtask

	task automatic t_master();
		logic [7:0] n;
		host_u.wr(8'hf0, 8'h04);
		host_u.wr(8'hf8, 8'h03);
		chk("master en", 8'h01, {7'h0, master_en_q});
		tick_gap(n);
		chk("tick gap", 8'h05, n);
		host_u.wr(8'hf8, 8'h07);
		tick_gap(n);
		chk("slow gap", 8'h05 + dsc_pkg::MCLK_EXTRA[7:0], n);
		host_u.wr(8'hf8, 8'h06);
		chk("passthru off", 8'h00, {7'h0, passthru_en_q});
		host_u.wr(8'hf8, 8'h2e);
		chk("slave en", 8'h01, {7'h0, slave_en_q});
		chk("auto inc", 8'h01, {7'h0, auto_inc_q});
	endtask

	task automatic t_page_proto();
		host_u.page(8'h00);
		chk("page dsp", 8'h00, {7'h0, page_sensor_q});
		host_u.page(8'h01);
		chk("page sensor", 8'h01, {7'h0, page_sensor_q});
		host_u.wr(8'hfd, 8'h5c);
		host_u.wr(8'hfe, 8'ha3);
		rchk(8'hfe, 8'ha3);
		chk("cmd out", 8'h5c, proto_cmd_q);
		rchk(8'hfd, 8'h5c);
		host_u.wr(8'he0, 8'ha5);
		host_u.wr(8'hf7, 8'h3c);
		chk("block reset", 8'ha5, block_reset_q);
		chk("slave id", 8'h3c, slave_id_q);
	endtask

	// ************************************************************
	// run control
	// ************************************************************
	task automatic complete_run();
		$display("checks %0d mismatches %0d", n_checks, n_fail);
		if (n_fail == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	// free running clock, 40 ns
	initial
	begin
		clock = 1'b0;
		forever #20 clock = ~clock;
	end

	// hang guard, 5000 cycles, well past the expected run of under two hundred cycles
	initial
	begin
		#(40 * 5000);
		n_fail++;
		complete_run();
	end

	// main sequence
	initial
	begin
		n_fail    = 0;
		n_checks  = 0;
		rst_n     = 1'b0;
		bist_err  = 4'h0;
		bist_busy = 1'b0;
		repeat (10) @(negedge clock);
		rst_n = 1'b1;
		t_reset_values();
		t_reserved();
		t_pointer();
		t_selftest();
		t_master();
		t_page_proto();
		complete_run();
	end
endmodule
